//--- dmc_cfg.svh
`ifndef DMC_CFG_SVH
`define DMC_CFG_SVH
// ------------------------------------------------------------
// Register reset and field constants
// ------------------------------------------------------------
`define DMC_CFG_RESET 8'h00
`define DMC_FULL_DUTY 16'hffff
`define DMC_TP_UNIT 16'h2000
`define DMC_TP_GAIN_UNIT 8'h20
`define DMC_EXP_START 16'hffff
`define DMC_EXP_STEP 16'hf604
`define DMC_EXP_TOP 8'hff
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DMC_CLK_KHZ 200000
`define DMC_TIMEOUT_MS 20
`define DMC_TIMEOUT_CYC (`DMC_TIMEOUT_MS * `DMC_CLK_KHZ)
`define DMC_DIM_MIN_HZ 100
`define DMC_PER_MIN_CYC (`DMC_CLK_KHZ * 1000 / `DMC_DIM_MIN_HZ)
`endif

//--- dmc_pkg.sv
package dmc_pkg;
   typedef struct packed {
      logic reg_source_select;
      logic direct_passthrough;
      logic [2:0] freq_field;
      logic exponential_curve_select;
      logic mixed_dimming_select;
      logic local_gain_select;
   } dmc_cfg_t;
   typedef struct packed {
      logic [7:0] gain;
      logic [15:0] duty;
      logic [2:0] freq_sel;
   } dmc_drive_t;
   typedef enum logic {EXP_IDLE, EXP_RUN} dmc_exp_state_t;
endpackage

//--- dmc_exp_curve.sv
`timescale 1ns/100ps
`include "dmc_cfg.svh"
module dmc_exp_curve (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] code,
   output logic [15:0] bright
);
   import dmc_pkg::*;
   dmc_exp_state_t state_r, state_nxt;
   logic [15:0] acc_r, acc_nxt, bright_r, bright_nxt;
   logic [7:0] rem_r, rem_nxt;
   logic [31:0] prod;

   // ------------------------------------------------------------
   // Repeated multiply by the step ratio, once per missing code
   // ------------------------------------------------------------
   always_comb begin
      prod = {16'h0, acc_r} * {16'h0, `DMC_EXP_STEP};
      state_nxt = state_r;
      acc_nxt = acc_r;
      rem_nxt = rem_r;
      bright_nxt = bright_r;
      unique case (state_r)
         EXP_IDLE: begin
            acc_nxt = `DMC_EXP_START;
            rem_nxt = `DMC_EXP_TOP - code; // RULE15
            state_nxt = EXP_RUN;
         end
         EXP_RUN: begin
            if (rem_r == 8'h00) begin
               bright_nxt = acc_r;
               state_nxt = EXP_IDLE;
            end else begin
               acc_nxt = prod[31:16]; // RULE15
               rem_nxt = rem_r - 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= EXP_IDLE;
         acc_r <= 16'h0;
         rem_r <= 8'h0;
         bright_r <= 16'h0;
      end else begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         rem_r <= rem_nxt;
         bright_r <= bright_nxt;
      end
   end

   assign bright = bright_r;

   exp_done_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE15
      state_r == EXP_RUN |-> ##[0:256] state_r == EXP_IDLE)
      else $error("exponential conversion did not finish");
   exp_top_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE15
      state_r == EXP_IDLE && code == 8'hff ##1 state_r == EXP_RUN ##1 1'b1 |-> bright_r == 16'hffff)
      else $error("top code must give full brightness");
endmodule

//--- dmc_top.sv
`timescale 1ns/100ps
`include "dmc_cfg.svh"
// Overview of operation
// (RULE1) Config 00xxx000: measured input duty drives all outputs linearly, shared gain.
// (RULE2) Config 00xxx100: measured duty goes through exponential law, shared gain.
// (RULE3) Config 01xxxx00: synchronised input drives outputs directly; curve bit ignored.
// (RULE4) Config 00xxx010: measured duty is brightness, split into gain and duty.
// (RULE5) Config 00xxx110: duty quantised to 8 bits, exponential law, then split.
// (RULE6) Sampling modes: outputs off after input stays low longer than 20 ms.
// (RULE7) Non-mixed global modes: every channel uses the global gain.
// (RULE8) Mixed, below threshold: gain at threshold level, duty is brightness over threshold.
// (RULE9) Mixed, at or above threshold: gain equals brightness, duty held at 100%.
// (RULE10) Sampling modes: output frequency picked from a fixed set by measured frequency.
// (RULE11) Local gain option: per-channel gains used, mixed dimming disabled.
// (RULE12) Mixed dimming always applies one brightness to all channels.
// (RULE13) Software treats x bits as don't care; frequency field is user chosen.
// (RULE14) Threshold field 00..11 gives 12.5, 25, 37.5, 50 percent.
// (RULE15) Exponential law: brightness is 0.961 to the power 255 minus code.
// (RULE16) Register modes take output frequency from the config frequency field.
// (RULE17) Config bits: 7 source, 6 direct, 5:3 freq, 2 curve, 1 mixed, 0 local.
// (RULE18) Timeout and measurement counters restart on each input rising edge.
module dmc_top #(
   parameter logic [23:0] TIMEOUT_CYC = 24'(`DMC_TIMEOUT_CYC),
   parameter logic [23:0] PER_MIN_CYC = 24'(`DMC_PER_MIN_CYC),
   parameter int CHANNELS = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pulse_dim_input,
   input wire logic cfg_write,
   input wire logic [7:0] cfg_wdata,
   output dmc_pkg::dmc_cfg_t dimming_config,
   input wire logic [7:0] global_current_gain,
   input wire logic [CHANNELS-1:0][7:0] channel_current_gain,
   input wire logic [15:0] global_duty_value,
   input wire logic [1:0] transition_point_field,
   output logic [CHANNELS-1:0] channel_on,
   output logic [CHANNELS-1:0][7:0] channel_gain,
   output dmc_pkg::dmc_drive_t drive_status
);
   import dmc_pkg::*;

   function automatic logic [15:0] frac16(input logic [23:0] num, input logic [23:0] den);
      logic [39:0] q;
      q = {num, 16'h0} / {16'h0, den};
      if (den == 24'h0)
         return 16'h0;
      else if (q > 40'h000000ffff)
         return `DMC_FULL_DUTY;
      else
         return q[15:0];
   endfunction

   // ------------------------------------------------------------
   // Configuration register
   // ------------------------------------------------------------
   dmc_cfg_t cfg_r, cfg_nxt;
   always_comb begin
      cfg_nxt = cfg_r;
      if (cfg_write)
         cfg_nxt = dmc_cfg_t'(cfg_wdata); // RULE17
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         cfg_r <= dmc_cfg_t'(`DMC_CFG_RESET);
      else
         cfg_r <= cfg_nxt;
   end
   assign dimming_config = cfg_r;

   logic reg_act, direct_act, mix_act, local_act, sample_act;
   assign reg_act = cfg_r.reg_source_select;
   assign direct_act = !reg_act && cfg_r.direct_passthrough; // RULE3
   assign local_act = cfg_r.local_gain_select; // RULE11
   assign mix_act = cfg_r.mixed_dimming_select && !local_act && !direct_act; // RULE11 RULE12
   assign sample_act = !reg_act && !direct_act;

   // ------------------------------------------------------------
   // Input synchroniser and measurement
   // ------------------------------------------------------------
   logic p_s1_r, p_s2_r, p_d_r, rise;
   logic [23:0] cnt_r, cnt_nxt, high_r, high_nxt, low_r, low_nxt;
   logic [23:0] per_r, per_nxt, hi_cap_r, hi_cap_nxt;
   logic [15:0] meas_duty_r, meas_duty_nxt;
   logic [2:0] meas_fsel_r, meas_fsel_nxt;
   logic timed_out;

   assign rise = p_s2_r && !p_d_r;
   assign timed_out = low_r > TIMEOUT_CYC; // RULE6

   always_comb begin
      cnt_nxt = (cnt_r == 24'hffffff) ? cnt_r : cnt_r + 24'h1;
      high_nxt = high_r + {23'h0, p_s2_r && high_r != 24'hffffff};
      per_nxt = per_r;
      hi_cap_nxt = hi_cap_r;
      if (rise) begin
         per_nxt = cnt_r; // RULE18
         hi_cap_nxt = high_r;
         cnt_nxt = 24'h1;
         high_nxt = 24'h1;
      end
      low_nxt = p_s2_r ? 24'h0 : (timed_out ? low_r : low_r + 24'h1); // RULE18
      meas_duty_nxt = frac16(hi_cap_r, per_r); // RULE1
      meas_fsel_nxt = 3'd7;
      for (int k = 7; k >= 0; k--) begin
         if ((PER_MIN_CYC >> k) <= per_r)
            meas_fsel_nxt = 3'(k); // RULE10
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         p_s1_r <= 1'b0;
         p_s2_r <= 1'b0;
         p_d_r <= 1'b0;
         cnt_r <= 24'h0;
         high_r <= 24'h0;
         low_r <= 24'h0;
         per_r <= 24'h0;
         hi_cap_r <= 24'h0;
         meas_duty_r <= 16'h0;
         meas_fsel_r <= 3'd0;
      end else begin
         p_s1_r <= pulse_dim_input;
         p_s2_r <= p_s1_r;
         p_d_r <= p_s2_r;
         cnt_r <= cnt_nxt;
         high_r <= high_nxt;
         low_r <= low_nxt;
         per_r <= per_nxt;
         hi_cap_r <= hi_cap_nxt;
         meas_duty_r <= meas_duty_nxt;
         meas_fsel_r <= meas_fsel_nxt;
      end
   end

   // ------------------------------------------------------------
   // Brightness source, curve and mixed split
   // ------------------------------------------------------------
   logic [15:0] lin_val, exp_val, bright, tp16;
   logic [7:0] code8, tp_gain;
   assign lin_val = reg_act ? global_duty_value : meas_duty_r;
   assign code8 = lin_val[15:8]; // RULE5

   dmc_exp_curve u_exp (
      .clock(clock),
      .rst_n(rst_n),
      .code(code8),
      .bright(exp_val)
   );

   assign bright = cfg_r.exponential_curve_select ? exp_val : lin_val; // RULE2 RULE5
   assign tp16 = 16'(({1'b0, transition_point_field} + 3'd1) * `DMC_TP_UNIT); // RULE14
   assign tp_gain = 8'(({1'b0, transition_point_field} + 3'd1) * `DMC_TP_GAIN_UNIT); // RULE14

   dmc_drive_t drv_r, drv_nxt;
   always_comb begin
      drv_nxt.gain = global_current_gain; // RULE7
      drv_nxt.duty = bright; // RULE1
      drv_nxt.freq_sel = reg_act ? cfg_r.freq_field : meas_fsel_r; // RULE10 RULE16
      if (mix_act) begin // RULE4 RULE5
         if (bright < tp16) begin
            drv_nxt.gain = tp_gain; // RULE8
            drv_nxt.duty = frac16({8'h0, bright}, {8'h0, tp16}); // RULE8
         end else begin
            drv_nxt.gain = bright[15:8]; // RULE9
            drv_nxt.duty = `DMC_FULL_DUTY; // RULE9
         end
      end
   end

   // ------------------------------------------------------------
   // Output pulse generator and channel drive
   // ------------------------------------------------------------
   logic [23:0] pcnt_r, pcnt_nxt, per_sel;
   logic [39:0] prod;
   logic [CHANNELS-1:0] on_r, on_nxt;
   logic [CHANNELS-1:0][7:0] gain_r, gain_nxt;
   logic pwm_on;

   always_comb begin
      per_sel = PER_MIN_CYC >> drv_r.freq_sel;
      prod = {16'h0, per_sel} * {24'h0, drv_r.duty};
      pcnt_nxt = (pcnt_r >= per_sel - 24'h1) ? 24'h0 : pcnt_r + 24'h1;
      pwm_on = (drv_r.duty == `DMC_FULL_DUTY) || (pcnt_r < prod[39:16]);
      if (direct_act)
         on_nxt = {CHANNELS{p_s2_r}}; // RULE3
      else if (sample_act && timed_out)
         on_nxt = '0; // RULE6
      else
         on_nxt = {CHANNELS{pwm_on}}; // RULE12
      for (int c = 0; c < CHANNELS; c++) begin
         gain_nxt[c] = local_act ? channel_current_gain[c] : drv_r.gain; // RULE7 RULE11
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         drv_r <= '0;
         pcnt_r <= 24'h0;
         on_r <= '0;
         gain_r <= '0;
      end else begin
         drv_r <= drv_nxt;
         pcnt_r <= pcnt_nxt;
         on_r <= on_nxt;
         gain_r <= gain_nxt;
      end
   end

   assign channel_on = on_r;
   assign channel_gain = gain_r;
   assign drive_status = drv_r;

   timeout_off_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
      sample_act && low_r > TIMEOUT_CYC |=> channel_on == '0)
      else $error("outputs not off after low timeout");
   direct_follow_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
      direct_act |=> channel_on == {CHANNELS{$past(p_s2_r)}})
      else $error("direct mode does not follow input");
   mixed_low_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
      mix_act && bright < tp16 |=> drive_status.gain == $past(tp_gain))
      else $error("mixed gain not at threshold level");
   mixed_high_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
      mix_act && bright >= tp16 |=> drive_status.duty == 16'hffff && drive_status.gain == $past(bright[15:8]))
      else $error("mixed high range not full duty");
   global_gain_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
      !mix_act && !local_act ##1 !local_act |=> channel_gain[0] == $past(global_current_gain, 2))
      else $error("global gain not applied");
   local_gain_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE11
      local_act |=> channel_gain == $past(channel_current_gain) && !$past(mix_act))
      else $error("local gains not applied");
   reg_freq_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE16
      reg_act |=> drive_status.freq_sel == $past(cfg_r.freq_field))
      else $error("register frequency field not used");
   rise_restart_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE18
      rise |=> cnt_r == 24'h1 && low_r == 24'h0 && per_r == $past(cnt_r))
      else $error("measurement not restarted on rising edge");
   linear_pass_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
      sample_act && !cfg_r.exponential_curve_select && !mix_act |=> drive_status.duty == $past(meas_duty_r))
      else $error("linear duty not passed through");
endmodule

//--- dmc_host_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host driving the pulse dimming pin
// ------------------------------------------------------------
module dmc_host_model (
   input wire logic clock,
   input wire logic run,
   input wire logic [15:0] period_cyc,
   input wire logic [15:0] high_cyc,
   input wire logic level,
   output logic pulse_dim_input = 1'b0
);
   logic [15:0] cnt_r = 16'h0000;
   // Pulse train when running, plain level otherwise
   always @(negedge clock) begin
      if (!run) begin
         cnt_r <= 16'h0000;
         pulse_dim_input <= level;
      end else begin
         cnt_r <= (cnt_r + 16'h0001 >= period_cyc) ? 16'h0000 : cnt_r + 16'h0001;
         pulse_dim_input <= (cnt_r < high_cyc);
      end
   end
endmodule

//--- dmc_top_test.sv
`timescale 1ns/100ps
module dmc_top_test;
   import dmc_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cfg_write = 1'b0;
   logic [7:0] cfg_wdata = 8'h00;
   logic [7:0] ggain = 8'h00;
   logic [31:0] chg = 32'h0;
   logic [15:0] gduty = 16'h0000;
   logic [1:0] tpf = 2'h1;
   logic run = 1'b0;
   logic level = 1'b0;
   logic [15:0] per = 16'd300;
   logic [15:0] hi = 16'd75;
   logic pin;
   dmc_cfg_t cfg_rd;
   logic [3:0] ch_on;
   logic [3:0][7:0] ch_gain;
   dmc_drive_t drv;
   int miscompares = 0;
   int cmp_count = 0;
   int on_cnt = 0;
   int cycles = 0;
   integer seed = 7;
   logic [34:0] exp_q[$];
   event look_ev;
   logic [15:0] tbl_per[4] = '{16'd1100, 16'd400, 16'd100, 16'd5};
   logic [2:0] tbl_fs[4] = '{3'h0, 3'h2, 3'h4, 3'h7};
   logic [15:0] mx_hi[3] = '{16'd40, 16'd100, 16'd200};
   logic [7:0] mx_g[3] = '{8'h40, 8'h40, 8'h80};
   logic [15:0] mx_d[3] = '{16'h6664, 16'hffff, 16'hffff};
   always #2.5 clock = ~clock;
   dmc_host_model host (.clock(clock), .run(run), .period_cyc(per), .high_cyc(hi), .level(level),
      .pulse_dim_input(pin));
   dmc_top #(.TIMEOUT_CYC(24'd200), .PER_MIN_CYC(24'd1024), .CHANNELS(4)) DUT (.clock(clock),
      .rst_n(rst_n), .pulse_dim_input(pin), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata),
      .dimming_config(cfg_rd), .global_current_gain(ggain), .channel_current_gain(chg),
      .global_duty_value(gduty), .transition_point_field(tpf), .channel_on(ch_on),
      .channel_gain(ch_gain), .drive_status(drv));
   // ------------------------------------------------------------
   // Checking
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Selector: 0 config, 1 duty, 2 gain, 3 freq, 4 on, 5 channel gains, 6 on count
   task automatic note(input logic [2:0] sel, input logic [31:0] exp);
      exp_q.push_back({sel, exp});
      -> look_ev;
   endtask
   always @(look_ev) begin : monitor
      logic [34:0] e;
      logic [31:0] seen;
      while (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         case (e[34:32])
            3'h0: seen = {24'h0, cfg_rd};
            3'h1: seen = {16'h0, drv.duty};
            3'h2: seen = {24'h0, drv.gain};
            3'h3: seen = {29'h0, drv.freq_sel};
            3'h4: seen = {28'h0, ch_on};
            3'h6: seen = on_cnt;
            default: seen = ch_gain;
         endcase
         check(seen, e[31:0]);
      end
   end
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         close_out();
      end
   end
   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] v);
      cfg_write = 1'b1;
      cfg_wdata = v;
      @(negedge clock);
      cfg_write = 1'b0;
   endtask
   task automatic pulse(input logic [15:0] p, input logic [15:0] h, input int n);
      per = p;
      hi = h;
      run = 1'b1;
      repeat (n) @(negedge clock);
   endtask
   initial begin
      logic [7:0] v;
      repeat (6) @(negedge clock);
      note(3'h0, 32'h0);
      note(3'h4, 32'h0);
      rst_n = 1'b1;
      v = 8'($random(seed));
      cfg_write = 1'b1;
      cfg_wdata = v;
      @(negedge clock);
      note(3'h0, {24'h0, v});
      cfg_wdata = ~v;
      @(negedge clock);
      note(3'h0, {24'h0, ~v});
      ggain = 8'($random(seed));
      v = 8'($random(seed));
      wr({2'b00, v[2:0], 3'b000});
      pulse(16'd300, 16'd75, 1000);
      note(3'h1, 32'h4000);
      note(3'h3, 32'h2);
      note(3'h5, {4{ggain}});
      for (int i = 0; i < 4; i++) begin
         pulse(tbl_per[i], tbl_per[i] >> 1, 4 * tbl_per[i] + 40);
         note(3'h3, {29'h0, tbl_fs[i]});
      end
      tpf = 2'h1;
      wr({2'b00, v[5:3], 3'b010});
      for (int i = 0; i < 3; i++) begin
         pulse(16'd400, mx_hi[i], 1400);
         note(3'h2, {24'h0, mx_g[i]});
         note(3'h1, {16'h0, mx_d[i]});
         note(3'h5, {4{mx_g[i]}});
      end
      wr({2'b00, v[5:3], 3'b100});
      pulse(16'd300, 16'd299, 1400);
      note(3'h1, 32'hffff);
      note(3'h5, {4{ggain}});
      pulse(16'd300, 16'd298, 1400);
      note(3'h1, 32'hf603);
      tpf = v[1:0];
      wr({2'b00, v[5:3], 3'b110});
      pulse(16'd300, 16'd299, 1400);
      note(3'h2, 32'hff);
      note(3'h1, 32'hffff);
      chg = $random(seed);
      for (int i = 0; i < 2; i++) begin
         wr({2'b00, v[5:3], 1'b0, i[0], 1'b1});
         pulse(16'd300, 16'd75, 1000);
         note(3'h5, chg);
         note(3'h1, 32'h4000);
      end
      wr({2'b01, v[5:2], 2'b00});
      run = 1'b0;
      level = 1'b1;
      repeat (6) @(negedge clock);
      note(3'h4, 32'hf);
      level = 1'b0;
      repeat (6) @(negedge clock);
      note(3'h4, 32'h0);
      wr(8'h00);
      pulse(16'd300, 16'd150, 1000);
      on_cnt = 0;
      repeat (256) begin
         @(negedge clock);
         on_cnt += (ch_on == 4'hf);
      end
      note(3'h6, 32'h80);
      run = 1'b0;
      repeat (215) @(negedge clock);
      note(3'h4, 32'h0);
      repeat (128) @(negedge clock);
      note(3'h4, 32'h0);
      gduty = 16'($random(seed));
      wr(8'h98);
      repeat (20) @(negedge clock);
      note(3'h3, 32'h3);
      note(3'h1, {16'h0, gduty});
      repeat (2) @(negedge clock);
      close_out();
   end
endmodule
